/* verilog/gbsc_map.svh */
/*
 * constants of the guarded byte store, clip and compare datapath:
 * widths and reset values. assumes nothing; definitions only.
 */
`ifndef GBSC_MAP_SVH
`define GBSC_MAP_SVH

`define GBSC_DATA_WIDTH 32
`define GBSC_BYTE_WIDTH 8
`define GBSC_DISP_WIDTH 7
`define GBSC_SEL_WIDTH 2
`define GBSC_GUARD_BIT 0
`define GBSC_ADDR_RESET 32'h0000_0000
`define GBSC_DATA_RESET 32'h0000_0000
`define GBSC_BYTE_RESET 8'h00
`define GBSC_TRUE_WORD 32'h0000_0001
`define GBSC_FALSE_WORD 32'h0000_0000

`endif

/* verilog/gbsc_pkg.sv */
/*
 * types of the guarded byte store, clip and compare datapath.
 * assumes the issue logic presents one operation code per cycle.
 */
package gbsc_pkg;

    // operations this datapath executes
    typedef enum logic [2:0] {
        GBSC_OP_STORE_BYTE,
        GBSC_OP_BYTE_SELECT,
        GBSC_OP_CLIP_SIGNED,
        GBSC_OP_CLIP_UNSIGNED,
        GBSC_OP_COMPARE_EQUAL
    } gbsc_op_type;

endpackage : gbsc_pkg

/* verilog/gbsc_datapath.sv */
/*
 * execution datapath for guarded operations: a byte store with signed
 * displacement toward the data memory unit, unsigned byte selection,
 * signed-to-unsigned clip, unsigned-to-unsigned clip and unsigned
 * equality compare. every operation is qualified by guard bit 0.
 * assumes operands come from logic on core_clk (no synchronisers) and
 * that the memory unit takes one byte store per cycle without stalling.
 */
`timescale 1ns/10ps
`include "gbsc_map.svh"

// Summary of operation
// RQ1 - store writes low byte of second source
// RQ2 - displacement is 7-bit, -64 through 63
// RQ3 - byte placement ignores the byte order bit
// RQ4 - aperture byte stores left undefined
// RQ5 - guard low stores nothing, no side effects
// RQ6 - byte select picks byte, zero-extends
// RQ7 - selector above 3 gives unspecified result
// RQ8 - signed clip into 0 through second source
// RQ9 - unsigned clip returns smaller unsigned operand
// RQ10 - equality compare writes one or zero
// RQ11 - destination written only when guard set
// RQ12 - displacement sign-extended, address wraps modulo 2^32
module gbsc_datapath #(
    parameter int DATA_WIDTH = `GBSC_DATA_WIDTH,
    parameter int DISP_WIDTH = `GBSC_DISP_WIDTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire gbsc_pkg::gbsc_op_type issue_op,
    input wire logic [DATA_WIDTH-1:0] guard_register,
    input wire logic [DATA_WIDTH-1:0] first_source,
    input wire logic [DATA_WIDTH-1:0] second_source,
    input wire logic [DISP_WIDTH-1:0] store_displacement,
    output logic mem_store_valid,
    output logic [DATA_WIDTH-1:0] mem_store_addr,
    output logic [`GBSC_BYTE_WIDTH-1:0] mem_store_data,
    output logic dest_write,
    output logic [DATA_WIDTH-1:0] dest_data
);

    // sign-extend the displacement to the datapath width
    function automatic logic [DATA_WIDTH-1:0] sext_disp(
        input logic [DISP_WIDTH-1:0] disp
    );
        sext_disp = {{(DATA_WIDTH-DISP_WIDTH){disp[DISP_WIDTH-1]}}, disp};
    endfunction : sext_disp

    // byte select: only the low selector bits steer the mux
    function automatic logic [DATA_WIDTH-1:0] select_byte(
        input logic [DATA_WIDTH-1:0] src,
        input logic [DATA_WIDTH-1:0] sel
    );
        logic [`GBSC_SEL_WIDTH-1:0] idx;
        idx = sel[`GBSC_SEL_WIDTH-1:0];
        select_byte = {{(DATA_WIDTH-`GBSC_BYTE_WIDTH){1'b0}},
                       src[idx*`GBSC_BYTE_WIDTH +: `GBSC_BYTE_WIDTH]};
    endfunction : select_byte

    // min(max(a, 0), b) with a signed and b unsigned
    function automatic logic [DATA_WIDTH-1:0] clip_signed(
        input logic [DATA_WIDTH-1:0] a,
        input logic [DATA_WIDTH-1:0] b
    );
        if (a[DATA_WIDTH-1]) begin
            clip_signed = '0;
        end else if (a > b) begin
            clip_signed = b;
        end else begin
            clip_signed = a;
        end
    endfunction : clip_signed

    // unsigned clip: the smaller of the two unsigned values
    function automatic logic [DATA_WIDTH-1:0] clip_unsigned(
        input logic [DATA_WIDTH-1:0] a,
        input logic [DATA_WIDTH-1:0] b
    );
        clip_unsigned = (a > b) ? b : a;
    endfunction : clip_unsigned

    logic guard_true;
    logic store_fire;
    logic alu_fire;
    logic [DATA_WIDTH-1:0] store_addr_next;
    logic [DATA_WIDTH-1:0] alu_result_next;

    // guard and issue qualification
    assign guard_true = guard_register[`GBSC_GUARD_BIT];
    assign store_fire = issue_valid && guard_true &&
                        (issue_op == gbsc_pkg::GBSC_OP_STORE_BYTE); // RQ5
    assign alu_fire = issue_valid && guard_true &&
                      (issue_op != gbsc_pkg::GBSC_OP_STORE_BYTE); // RQ11

    // address wraps naturally in the fixed-width adder; every 7-bit code
    // is a legal displacement so no range error exists
    assign store_addr_next = first_source +
                             sext_disp(store_displacement); // RQ12 RQ2

    // result of the register-to-register operations
    always_comb begin
        case (issue_op)
            gbsc_pkg::GBSC_OP_BYTE_SELECT: begin
                // RQ6 RQ7
                alu_result_next = select_byte(first_source, second_source);
            end
            gbsc_pkg::GBSC_OP_CLIP_SIGNED: begin
                // RQ8
                alu_result_next = clip_signed(first_source, second_source);
            end
            gbsc_pkg::GBSC_OP_CLIP_UNSIGNED: begin
                // RQ9
                alu_result_next = clip_unsigned(first_source, second_source);
            end
            gbsc_pkg::GBSC_OP_COMPARE_EQUAL: begin
                alu_result_next = (first_source == second_source) ?
                    `GBSC_TRUE_WORD : `GBSC_FALSE_WORD; // RQ10
            end
            default: begin
                alu_result_next = dest_data;
            end
        endcase
    end

    // store strobe: a false guard raises nothing, so the cache sees no
    // access and its replacement state stays untouched
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_store_valid <= 1'b0;
        end else begin
            mem_store_valid <= store_fire; // RQ5
        end
    end

    // store address and byte, loaded only by a taken store; a single byte
    // has no byte order, and aperture targets get no special handling
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_store_addr <= `GBSC_ADDR_RESET;
            mem_store_data <= `GBSC_BYTE_RESET;
        end else if (store_fire) begin
            mem_store_addr <= store_addr_next; // RQ12 RQ4
            mem_store_data <= second_source[`GBSC_BYTE_WIDTH-1:0]; // RQ1 RQ3
        end
    end

    // destination write strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dest_write <= 1'b0;
        end else begin
            dest_write <= alu_fire; // RQ11
        end
    end

    // destination value holds its old contents under a false guard
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dest_data <= `GBSC_DATA_RESET;
        end else if (alu_fire) begin
            dest_data <= alu_result_next; // RQ11
        end
    end

    // every result is registered, so the checks below judge the outputs
    // one edge after the issue edge that they qualify
    default clocking chk_clk @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // an issued operation of a given kind, guard taken or not
    sequence seq_issue(gbsc_pkg::gbsc_op_type op, logic g);
        issue_valid && issue_op == op && guard_true == g;
    endsequence

    sequence seq_store_taken;
        seq_issue(gbsc_pkg::GBSC_OP_STORE_BYTE, 1'b1);
    endsequence

    chk_store_address: assert property ( // RQ12
        seq_store_taken |=> mem_store_valid &&
            mem_store_addr == $past(first_source) +
                sext_disp($past(store_displacement)))
        else $error("store address is not base plus displacement");

    chk_store_byte: assert property ( // RQ1
        seq_store_taken |=> mem_store_data ==
            $past(second_source[`GBSC_BYTE_WIDTH-1:0]))
        else $error("stored byte is not the low source byte");

    chk_store_guarded: assert property ( // RQ5
        seq_issue(gbsc_pkg::GBSC_OP_STORE_BYTE, 1'b0) |=>
            !mem_store_valid && $stable(mem_store_addr) &&
            $stable(mem_store_data))
        else $error("store with false guard had an effect");

    chk_store_cause: assert property ( // RQ5
        mem_store_valid |-> $past(store_fire))
        else $error("store strobe without a taken store");

    // a taken byte select whose selector lies in the defined range
    sequence seq_select_taken;
        seq_issue(gbsc_pkg::GBSC_OP_BYTE_SELECT, 1'b1) ##0
            second_source < 32'h0000_0004;
    endsequence

    chk_byte_select: assert property ( // RQ6
        seq_select_taken |=>
            dest_write && dest_data == (($past(first_source) >>
                {$past(second_source[`GBSC_SEL_WIDTH-1:0]), 3'b000}) &
                32'h0000_00ff))
        else $error("byte select result wrong");

    chk_clip_signed: assert property ( // RQ8
        seq_issue(gbsc_pkg::GBSC_OP_CLIP_SIGNED, 1'b1) |=>
            dest_write && dest_data == (
                $past(first_source[DATA_WIDTH-1]) ? {DATA_WIDTH{1'b0}} :
                $past(first_source) > $past(second_source) ?
                $past(second_source) : $past(first_source)))
        else $error("signed clip result out of range");

    chk_clip_unsigned: assert property ( // RQ9
        seq_issue(gbsc_pkg::GBSC_OP_CLIP_UNSIGNED, 1'b1) |=>
            dest_write && dest_data == ($past(first_source) >
                $past(second_source) ? $past(second_source) :
                $past(first_source)))
        else $error("unsigned clip result wrong");

    chk_compare_equal: assert property ( // RQ10
        seq_issue(gbsc_pkg::GBSC_OP_COMPARE_EQUAL, 1'b1) |=>
            dest_write && dest_data == ($past(first_source) ==
                $past(second_source) ? `GBSC_TRUE_WORD : `GBSC_FALSE_WORD))
        else $error("compare result wrong");

    chk_dest_hold: assert property ( // RQ11
        !alu_fire |=> !dest_write && $stable(dest_data))
        else $error("destination changed without a taken operation");

    // a taken operation of the register-to-register group
    sequence seq_alu_taken;
        issue_valid && guard_true &&
            issue_op != gbsc_pkg::GBSC_OP_STORE_BYTE;
    endsequence

    // a store followed at once by a register operation, both taken
    sequence seq_store_then_alu;
        seq_store_taken ##1 seq_alu_taken;
    endsequence

    // idle or refused cycles leave the store port exactly as it was;
    // a moving address would look like a second access to the cache
    chk_store_hold: assert property ( // RQ5
        !store_fire |=> !mem_store_valid && $stable(mem_store_addr) &&
            $stable(mem_store_data))
        else $error("store port moved without a taken store");

    // a register operation never reaches the memory unit
    chk_alu_no_store: assert property ( // RQ5
        seq_alu_taken |=> !mem_store_valid)
        else $error("register operation raised a store strobe");

    // a store never writes the destination register
    chk_store_no_dest: assert property ( // RQ11
        seq_store_taken |=> !dest_write && $stable(dest_data))
        else $error("store wrote the destination register");

    // address minus base must fall within -64 through 63 whatever the
    // base; judged apart from the adder so a wrong extension shows
    chk_disp_range: assert property ( // RQ2
        seq_store_taken |=>
            mem_store_addr - $past(first_source) + 32'h0000_0040 <
                32'h0000_0080)
        else $error("store displacement outside the 7-bit range");

    // the unsigned clip never exceeds either operand
    chk_clip_bounded: assert property ( // RQ9
        seq_issue(gbsc_pkg::GBSC_OP_CLIP_UNSIGNED, 1'b1) |=>
            dest_data <= $past(first_source) &&
            dest_data <= $past(second_source))
        else $error("unsigned clip above an operand");

    // a compare result is a single truth bit; the upper bits stay clear
    chk_compare_bool: assert property ( // RQ10
        seq_issue(gbsc_pkg::GBSC_OP_COMPARE_EQUAL, 1'b1) |=>
            dest_data[DATA_WIDTH-1:1] == '0)
        else $error("compare result has upper bits set");

    // back-to-back issue with no gap: the register write follows the
    // store by one cycle and the store port is left alone meanwhile
    chk_back_to_back: assert property ( // RQ11
        seq_store_then_alu |=> dest_write && !mem_store_valid &&
            $stable(mem_store_addr))
        else $error("store then register operation interfered");

    // the selected byte always arrives zero-extended
    chk_select_zero: assert property ( // RQ6
        seq_select_taken |=>
            dest_data[DATA_WIDTH-1:`GBSC_BYTE_WIDTH] == '0)
        else $error("selected byte not zero-extended");

    // a refused select leaves the destination untouched even though the
    // byte mux output differs; the write enable alone must stop it
    chk_select_refused: assert property ( // RQ11
        seq_issue(gbsc_pkg::GBSC_OP_BYTE_SELECT, 1'b0) |=>
            !dest_write && $stable(dest_data))
        else $error("refused select changed the destination");

    // a refused signed clip leaves the destination as it was
    chk_clip_refused: assert property ( // RQ11
        seq_issue(gbsc_pkg::GBSC_OP_CLIP_SIGNED, 1'b0) |=>
            !dest_write && $stable(dest_data))
        else $error("refused clip changed the destination");

endmodule : gbsc_datapath

/* testbench/gbsc_mem_model.sv */
/*
 * behavioural data memory behind the byte store port.
 * assumes one store strobe per core_clk cycle; it never stalls.
 */
`timescale 1ns/10ps
module gbsc_mem_model (
    input wire logic core_clk,
    input wire logic mem_store_valid,
    input wire logic [31:0] mem_store_addr,
    input wire logic [7:0] mem_store_data
);
    logic [7:0] mem [logic [31:0]];
    int write_count = 0;

    // sparse store: unwritten bytes read unknown, so a stray hit shows
    always @(posedge core_clk) begin
        if (mem_store_valid) begin
            mem[mem_store_addr] = mem_store_data;
            write_count++;
        end
    end
endmodule : gbsc_mem_model

/* testbench/tb_top.sv */
/*
 * self-checking bench of the guarded datapath: store, select, clips,
 * compare. assumes gbsc_mem_model stands on the store port.
 */
`timescale 1ns/10ps
module tb_top;
    localparam gbsc_pkg::gbsc_op_type op_st = gbsc_pkg::GBSC_OP_STORE_BYTE;
    localparam gbsc_pkg::gbsc_op_type op_sel = gbsc_pkg::GBSC_OP_BYTE_SELECT;
    localparam gbsc_pkg::gbsc_op_type op_ci = gbsc_pkg::GBSC_OP_CLIP_SIGNED;
    localparam gbsc_pkg::gbsc_op_type op_cu = gbsc_pkg::GBSC_OP_CLIP_UNSIGNED;
    localparam gbsc_pkg::gbsc_op_type op_eq = gbsc_pkg::GBSC_OP_COMPARE_EQUAL;
    logic core_clk, rst_n, issue_valid, mem_store_valid, dest_write;
    gbsc_pkg::gbsc_op_type issue_op;
    logic [31:0] guard_register, first_source, second_source;
    logic [31:0] mem_store_addr, dest_data;
    logic [6:0] store_displacement;
    logic [7:0] mem_store_data;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    gbsc_datapath u_gbsc_datapath (.core_clk(core_clk), .rst_n(rst_n),
        .issue_valid(issue_valid), .issue_op(issue_op),
        .guard_register(guard_register), .first_source(first_source),
        .second_source(second_source),
        .store_displacement(store_displacement),
        .mem_store_valid(mem_store_valid), .mem_store_addr(mem_store_addr),
        .mem_store_data(mem_store_data), .dest_write(dest_write),
        .dest_data(dest_data));
    gbsc_mem_model u_gbsc_mem_model (.core_clk(core_clk),
        .mem_store_valid(mem_store_valid), .mem_store_addr(mem_store_addr),
        .mem_store_data(mem_store_data));

    // free-running core clock
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    // hang guard: the whole run needs well under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one issue cycle, then strobes judged 1 ns after the edge that takes it
    task automatic run(input gbsc_pkg::gbsc_op_type op,
        input logic [31:0] g, a, b, input logic [6:0] d);
        logic st;
        st = (op == op_st);
        @(posedge core_clk);
        issue_valid <= 1'h1;
        issue_op <= op;
        guard_register <= g;
        first_source <= a;
        second_source <= b;
        store_displacement <= d;
        @(posedge core_clk);
        issue_valid <= 1'h0;
        #1;
        check({31'h0, mem_store_valid}, {31'h0, st & g[0]});
        check({31'h0, dest_write}, {31'h0, ~st & g[0]});
    endtask : run

    task automatic test_store();
        run(op_st, 32'h1, 32'h0000_0d00, 32'h4433_2211, 7'h03);
        check(mem_store_addr, 32'h0000_0d03);
        run(op_st, 32'h1, 32'h0000_0d02, 32'haabb_ccdd, 7'h7c);
        check(mem_store_addr, 32'h0000_0cfe);
        run(op_st, 32'h1, 32'h0000_0010, 32'h0000_00a5, 7'h40);
        check(mem_store_addr, 32'hffff_ffd0);
        run(op_st, 32'h1, 32'hffff_fff0, 32'h1234_565a, 7'h3f);
        check(mem_store_addr, 32'h0000_002f);
        @(posedge core_clk);
        #1;
        check({24'h0, u_gbsc_mem_model.mem[32'h0000_0d03]}, 32'h11);
        check({24'h0, u_gbsc_mem_model.mem[32'h0000_0cfe]}, 32'hdd);
        check({24'h0, u_gbsc_mem_model.mem[32'hffff_ffd0]}, 32'ha5);
        check({24'h0, u_gbsc_mem_model.mem[32'h0000_002f]}, 32'h5a);
        $display("test_store done");
    endtask : test_store

    // guard bit 1 set but bit 0 clear must still refuse
    task automatic test_guard();
        int n;
        logic [31:0] prev;
        n = u_gbsc_mem_model.write_count;
        prev = dest_data;
        run(op_st, 32'h2, 32'h0000_0d01, 32'haabb_ccdd, 7'h7c);
        run(op_cu, 32'h0, 32'h0000_0001, 32'h0000_0002, 7'h00);
        run(op_eq, 32'hffff_fffe, 32'h0000_0003, 32'h0000_0003, 7'h00);
        run(op_sel, 32'h0, 32'hddcc_bbaa, 32'h0000_0000, 7'h00);
        run(op_ci, 32'hffff_fffe, 32'h0000_0005, 32'h0000_0007, 7'h00);
        @(posedge core_clk);
        #1;
        check(u_gbsc_mem_model.write_count, n);
        check(mem_store_addr, 32'h0000_002f);
        check(dest_data, prev);
        $display("test_guard done");
    endtask : test_guard

    task automatic test_select();
        for (int i = 0; i < 4; i++) begin
            run(op_sel, 32'h1, 32'hddcc_bbaa, 32'(i), 7'h00);
            check(dest_data, (32'hddcc_bbaa >> (8 * i)) & 32'hff);
        end
        $display("test_select done");
    endtask : test_select

    task automatic test_clip();
        logic [31:0] a [4] = '{32'h80, 32'h8000_0000, 32'hffff_fff0, 32'h5};
        logic [31:0] b [4] = '{32'h7f, 32'h003f_ffff, 32'h10, 32'hffff_ffff};
        logic [31:0] s [4] = '{32'h7f, 32'h0, 32'h0, 32'h5};
        logic [31:0] u [4] = '{32'h7f, 32'h003f_ffff, 32'h10, 32'h5};
        for (int i = 0; i < 4; i++) begin
            run(op_ci, 32'h1, a[i], b[i], 7'h00);
            check(dest_data, s[i]);
            run(op_cu, 32'h1, a[i], b[i], 7'h00);
            check(dest_data, u[i]);
        end
        $display("test_clip done");
    endtask : test_clip

    task automatic test_compare();
        run(op_eq, 32'h1, 32'h0000_0003, 32'h0000_0004, 7'h00);
        check(dest_data, 32'h0);
        run(op_eq, 32'h1, 32'h8000_0000, 32'h8000_0000, 7'h00);
        check(dest_data, 32'h1);
        run(op_eq, 32'h1, 32'h8000_0000, 32'h0000_0004, 7'h00);
        check(dest_data, 32'h0);
        $display("test_compare done");
    endtask : test_compare

    // store and compare issued on adjacent edges, no idle cycle between
    task automatic test_back_to_back();
        @(posedge core_clk);
        issue_valid <= 1'h1;
        issue_op <= op_st;
        guard_register <= 32'h1;
        first_source <= 32'h0000_0d00;
        second_source <= 32'h0000_0077;
        store_displacement <= 7'h01;
        @(posedge core_clk);
        issue_op <= op_eq;
        first_source <= 32'h0000_0009;
        second_source <= 32'h0000_0009;
        #1;
        check({31'h0, mem_store_valid}, 32'h1);
        @(posedge core_clk);
        issue_valid <= 1'h0;
        #1;
        check({31'h0, mem_store_valid}, 32'h0);
        check({31'h0, dest_write}, 32'h1);
        check(dest_data, 32'h1);
        check(mem_store_addr, 32'h0000_0d01);
        check({24'h0, u_gbsc_mem_model.mem[32'h0000_0d01]}, 32'h77);
        $display("test_back_to_back done");
    endtask : test_back_to_back

    // all inputs defined at time zero, reset held six cycles
    initial begin
        rst_n = 1'h0;
        issue_valid = 1'h0;
        issue_op = op_st;
        guard_register = 32'h0;
        first_source = 32'h0;
        second_source = 32'h0;
        store_displacement = 7'h00;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        #1;
        check(dest_data, 32'h0);
        test_store();
        test_guard();
        test_select();
        test_clip();
        test_compare();
        test_back_to_back();
        print_verdict();
    end
endmodule : tb_top
